// >>> design/sarx_pkg.sv
// Constants for the secondary audio port receiver.
// Assumes byte address is four times the register index.
package sarx_pkg;
  localparam int unsigned NUM_CH    = 8;
  localparam int unsigned ADDR_W    = 8;
  localparam int unsigned SLOT_W    = 5;
  localparam int unsigned WORD_W    = 32;
  localparam int unsigned CHCFG_W   = 6;
  localparam int unsigned CTRL_W    = 6;
  // Register indices
  localparam logic [5:0] IDX_FRAMING   = 6'h26;
  localparam logic [5:0] IDX_PIN_SEL   = 6'h27;
  localparam logic [5:0] IDX_CHAN_BASE = 6'h28;
  localparam logic [5:0] IDX_CHAN_LAST = 6'h2f;
  localparam logic [5:0] IDX_CONTROL   = 6'h30;
  localparam logic [5:0] IDX_STATUS    = 6'h31;
  // Field positions
  localparam int unsigned FR_EDGE_BIT  = 7;
  localparam int unsigned FR_FSYNC_BIT = 6;
  localparam int unsigned FR_BCLK_BIT  = 5;
  localparam int unsigned CH_EN_BIT    = 5;
  localparam int unsigned CTL_MODE_BIT = 0;
  localparam int unsigned CTL_POL_BIT  = 1;
  localparam int unsigned CTL_FMT_LSB  = 2;
  localparam int unsigned CTL_WL_LSB   = 4;
  // Values after reset
  localparam logic [7:0] FRAMING_RST = 8'h00;
  localparam logic [7:0] PIN_SEL_RST = 8'h00;
  localparam logic [5:0] CONTROL_RST = 6'h00;
  // Framing counts, in bit-clock cycles or slots, and bus response codes
  localparam logic [5:0] I2S_DELAY  = 6'h01;
  localparam logic [4:0] HALF_BASE  = 5'h10;
  localparam logic [4:0] HALF_LAST  = 5'h0f;
  localparam logic [4:0] TDM_LAST   = 5'h1f;
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_ERR   = 2'h2;

  typedef enum logic [1:0] {
    FMT_TDM = 2'b00,
    FMT_I2S = 2'b01,
    FMT_LJ  = 2'b10
  } sarx_format_type;

  // Word length code to bit count
  function automatic logic [5:0] wl_bits(input logic [1:0] code);
    unique case (code)
      2'h0: wl_bits = 6'h10;
      2'h1: wl_bits = 6'h14;
      2'h2: wl_bits = 6'h18;
      2'h3: wl_bits = 6'h20;
    endcase
  endfunction
endpackage

// >>> design/sarx_sync.sv
// Two-stage synchroniser for levels entering a clock domain.
// Assumes each bit is a quasi-static level or a slow toggle.
`timescale 1ns/100ps
`default_nettype none
module sarx_sync #(
  parameter int unsigned WIDTH = 1
) (
  // Destination clock
  input  wire logic             clk,
  // Levels
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // No reset: first stage feeds only the second
  always_ff @(posedge clk) begin
    stage1   <= async_in;
    sync_out <= stage1;
  end
endmodule // sarx_sync
`default_nettype wire

// >>> design/sarx_shift.sv
// Serial-to-parallel shifter for one serial data input pin.
// Assumes shift_en is a one-cycle strobe on the latch edge.
`timescale 1ns/100ps
`default_nettype none
module sarx_shift #(
  parameter int unsigned WIDTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst_n,
  // Serial side
  input  wire logic             shift_en,
  input  wire logic             bit_in,
  // Word including the bit now arriving
  output logic      [WIDTH-1:0] word_now
);
  logic [WIDTH-1:0] shreg;

  assign word_now = {shreg[WIDTH-2:0], bit_in};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      shreg <= '0;
    end else if (shift_en) begin
      shreg <= word_now;
    end
  end
endmodule // sarx_shift
`default_nettype wire

// >>> design/sarx_top.sv
// Secondary audio port receiver and its registers.
// Assumes AXI4-Lite on aclk, pins sampled on link_clk,
// at least four times the serial bit clock rate.
//
// The AXI4-Lite interface to the registers is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// - Edge bit inverts the data latch edge.
// - Same latch edge for both data pins.
// - Controller mode may use internal frame sync.
// - Controller mode may use internal bit clock.
// - Offset delays slot-0 MSB by 0-31 cycles.
// - Offset applies to TDM and both halves.
// - Offset applies identically to both pins.
// - Per-channel bit picks first or second pin.
// - Configuration fields reset to zero, except channel slot fields, which reset to the channel number.
// - Enabled channel forwards its slot word.
module sarx_top (
  // System clock and reset
  input  wire logic                                 aclk,
  input  wire logic                                 aresetn,
  // AXI4-Lite write address
  input  wire logic [sarx_pkg::ADDR_W-1:0]          awaddr,
  input  wire logic                                 awvalid,
  output logic                                      awready,
  // AXI4-Lite write data and response
  input  wire logic [31:0]                          wdata,
  input  wire logic [3:0]                           wstrb,
  input  wire logic                                 wvalid,
  output logic                                      wready,
  output logic [1:0]                                bresp,
  output logic                                      bvalid,
  input  wire logic                                 bready,
  // AXI4-Lite read
  input  wire logic [sarx_pkg::ADDR_W-1:0]          araddr,
  input  wire logic                                 arvalid,
  output logic                                      arready,
  output logic [31:0]                               rdata,
  output logic [1:0]                                rresp,
  output logic                                      rvalid,
  input  wire logic                                 rready,
  // Link side
  input  wire logic                                 link_clk,
  input  wire logic                                 ext_bit_clock,
  input  wire logic                                 ext_frame_sync,
  input  wire logic                                 serial_input_pin_first,
  input  wire logic                                 serial_input_pin_second,
  input  wire logic                                 int_bit_clock,
  input  wire logic                                 int_frame_sync,
  // Received words towards the DAC channels
  output logic [sarx_pkg::NUM_CH*sarx_pkg::WORD_W-1:0] dac_data,
  output logic [sarx_pkg::NUM_CH-1:0]               dac_valid
);
  localparam int unsigned NCH = sarx_pkg::NUM_CH;
  localparam int unsigned WW  = sarx_pkg::WORD_W;
  localparam int unsigned CW  = sarx_pkg::CHCFG_W;
  localparam int unsigned XW  = sarx_pkg::CTRL_W + 16 + NCH * CW;

  function automatic logic idx_known(input logic [5:0] idx);
    idx_known = (idx == sarx_pkg::IDX_FRAMING) || (idx == sarx_pkg::IDX_PIN_SEL) ||
                ((idx >= sarx_pkg::IDX_CHAN_BASE) && (idx <= sarx_pkg::IDX_CHAN_LAST)) ||
                (idx == sarx_pkg::IDX_CONTROL) || (idx == sarx_pkg::IDX_STATUS);
  endfunction

  // Registers
  logic [7:0]             framing;
  logic [7:0]             pin_sel;
  logic [CW-1:0]          chan_cfg [NCH];
  logic [sarx_pkg::CTRL_W-1:0] control;
  logic [NCH-1:0]         rx_seen;
  logic [NCH*CW-1:0]      chan_flat;

  // Write channel
  logic                   aw_held;
  logic                   w_held;
  logic [sarx_pkg::ADDR_W-1:0] wr_addr;
  logic [31:0]            wr_data;
  logic                   wr_strb0;
  logic                   aw_take;
  logic                   w_take;
  logic                   next_aw_held;
  logic                   next_w_held;
  logic                   next_bvalid;
  logic                   do_write;
  logic [5:0]             wr_idx;
  logic [7:0]             wr_byte;
  logic                   wr_lane;

  always_comb begin
    aw_take      = awvalid & awready;
    w_take       = wvalid & wready;
    next_aw_held = aw_held | aw_take;
    next_w_held  = w_held | w_take;
    do_write     = next_aw_held & next_w_held & ~bvalid;
    next_bvalid  = do_write | (bvalid & ~bready);
    wr_idx       = aw_held ? wr_addr[7:2] : awaddr[7:2];
    wr_byte      = w_held ? wr_data[7:0] : wdata[7:0];
    wr_lane      = w_held ? wr_strb0 : wstrb[0];
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held  <= 1'b0;
      w_held   <= 1'b0;
      wr_addr  <= '0;
      wr_data  <= '0;
      wr_strb0 <= 1'b0;
      awready  <= 1'b0;
      wready   <= 1'b0;
      bvalid   <= 1'b0;
      bresp    <= sarx_pkg::RESP_OKAY;
    end else begin
      aw_held <= next_aw_held & ~do_write;
      w_held  <= next_w_held & ~do_write;
      if (aw_take) begin
        wr_addr <= awaddr;
      end
      if (w_take) begin
        wr_data  <= wdata;
        wr_strb0 <= wstrb[0];
      end
      awready <= ~(next_aw_held & ~do_write) & ~next_bvalid;
      wready  <= ~(next_w_held & ~do_write) & ~next_bvalid;
      bvalid  <= next_bvalid;
      if (do_write) begin
        bresp <= idx_known(wr_idx) ? sarx_pkg::RESP_OKAY : sarx_pkg::RESP_ERR;
      end
    end
  end

  // Status bits: a new word wins over a clear in the same cycle
  logic [NCH-1:0] word_event;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      framing <= sarx_pkg::FRAMING_RST;
      pin_sel <= sarx_pkg::PIN_SEL_RST;
      control <= sarx_pkg::CONTROL_RST;
    end else if (do_write && wr_lane) begin
      if (wr_idx == sarx_pkg::IDX_FRAMING) begin
        framing <= wr_byte;
      end
      if (wr_idx == sarx_pkg::IDX_PIN_SEL) begin
        pin_sel <= wr_byte;
      end
      if (wr_idx == sarx_pkg::IDX_CONTROL) begin
        control <= wr_byte[sarx_pkg::CTRL_W-1:0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rx_seen <= '0;
    end else if (do_write && wr_lane && wr_idx == sarx_pkg::IDX_STATUS) begin
      rx_seen <= (rx_seen & ~wr_byte) | word_event;
    end else begin
      rx_seen <= rx_seen | word_event;
    end
  end

  genvar gc;
  generate
    for (gc = 0; gc < NCH; gc++) begin : g_chcfg
      localparam logic [5:0] CH_IDX = sarx_pkg::IDX_CHAN_BASE + 6'(gc);
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          // Slot assignment resets to the channel's own number
          chan_cfg[gc] <= {1'b0, 5'(gc)};
        end else if (do_write && wr_lane && wr_idx == CH_IDX) begin
          chan_cfg[gc] <= wr_byte[CW-1:0];
        end
      end
      assign chan_flat[gc*CW +: CW] = chan_cfg[gc];
    end
  endgenerate

  // Read channel
  logic [5:0]  rd_idx;
  logic [31:0] rd_val;

  always_comb begin
    rd_idx = araddr[7:2];
    rd_val = '0;
    if (rd_idx == sarx_pkg::IDX_FRAMING) begin
      rd_val[7:0] = framing;
    end else if (rd_idx == sarx_pkg::IDX_PIN_SEL) begin
      rd_val[7:0] = pin_sel;
    end else if (rd_idx >= sarx_pkg::IDX_CHAN_BASE && rd_idx <= sarx_pkg::IDX_CHAN_LAST) begin
      rd_val[CW-1:0] = chan_cfg[3'(rd_idx - sarx_pkg::IDX_CHAN_BASE)];
    end else if (rd_idx == sarx_pkg::IDX_CONTROL) begin
      rd_val[sarx_pkg::CTRL_W-1:0] = control;
    end else if (rd_idx == sarx_pkg::IDX_STATUS) begin
      rd_val[NCH-1:0] = rx_seen;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= sarx_pkg::RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_val;
      rresp   <= idx_known(rd_idx) ? sarx_pkg::RESP_OKAY : sarx_pkg::RESP_ERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // Crossing into the link domain; configuration is changed while idle
  logic          link_rst_n;
  logic [XW-1:0] cfg_link;
  logic [3:0]    pins_s;

  sarx_sync #(.WIDTH(1)) u_rst_sync (
    .clk      (link_clk),
    .async_in (aresetn),
    .sync_out (link_rst_n)
  );

  sarx_sync #(.WIDTH(XW)) u_cfg_sync (
    .clk      (link_clk),
    .async_in ({control, framing, pin_sel, chan_flat}),
    .sync_out (cfg_link)
  );

  sarx_sync #(.WIDTH(4)) u_pin_sync (
    .clk      (link_clk),
    .async_in ({ext_bit_clock, ext_frame_sync, serial_input_pin_second, serial_input_pin_first}),
    .sync_out (pins_s)
  );

  logic [sarx_pkg::CTRL_W-1:0] l_ctrl;
  logic [7:0]                  l_framing;
  logic [7:0]                  l_pin_sel;
  logic [NCH*CW-1:0]           l_chan;
  sarx_pkg::sarx_format_type   l_fmt;
  logic [5:0]                  l_wl;

  assign {l_ctrl, l_framing, l_pin_sel, l_chan} = cfg_link;
  assign l_fmt = sarx_pkg::sarx_format_type'(l_ctrl[sarx_pkg::CTL_FMT_LSB +: 2]);
  assign l_wl  = sarx_pkg::wl_bits(l_ctrl[sarx_pkg::CTL_WL_LSB +: 2]);

  // Clock and frame-sync source, latch edge, half-frame detection
  logic       sel_bclk;
  logic       sel_fsync;
  logic       bclk_d;
  logic       fs_d;
  logic       latch;
  logic       half_start;
  logic       half;
  logic [5:0] start_pos;

  always_comb begin
    sel_bclk  = (l_ctrl[sarx_pkg::CTL_MODE_BIT] && l_framing[sarx_pkg::FR_BCLK_BIT]) ?
                int_bit_clock : pins_s[3];
    sel_fsync = (l_ctrl[sarx_pkg::CTL_MODE_BIT] && l_framing[sarx_pkg::FR_FSYNC_BIT]) ?
                int_frame_sync : pins_s[2];
    latch = (l_ctrl[sarx_pkg::CTL_POL_BIT] ^ l_framing[sarx_pkg::FR_EDGE_BIT]) ?
            (bclk_d & ~sel_bclk) : (~bclk_d & sel_bclk);
    half = 1'b0;
    half_start = 1'b0;
    unique case (l_fmt)
      sarx_pkg::FMT_TDM: half_start = sel_fsync & ~fs_d;
      sarx_pkg::FMT_I2S: begin
        half_start = sel_fsync ^ fs_d;
        half       = sel_fsync;
      end
      default: begin
        half_start = sel_fsync ^ fs_d;
        half       = ~sel_fsync;
      end
    endcase
    // offset added to the standard MSB position
    start_pos = {1'b0, l_framing[4:0]} + ((l_fmt == sarx_pkg::FMT_I2S) ? sarx_pkg::I2S_DELAY : 6'h00);
  end

  // Slot walker
  logic       running;
  logic [5:0] wait_cnt;
  logic [5:0] bitn;
  logic [4:0] slot;
  logic [4:0] slot_last;
  logic       eff_run;
  logic [5:0] eff_wait;
  logic [5:0] eff_bitn;
  logic [4:0] eff_slot;
  logic       shift_en;
  logic       word_done;

  always_comb begin
    eff_run   = half_start | running;
    eff_wait  = half_start ? start_pos : wait_cnt;
    eff_bitn  = half_start ? 6'h00 : bitn;
    eff_slot  = half_start ? (half ? sarx_pkg::HALF_BASE : 5'h00) : slot;
    shift_en  = latch & eff_run & (eff_wait == 6'h00);
    word_done = shift_en & (eff_bitn == l_wl - 6'h01);
    slot_last = (l_fmt == sarx_pkg::FMT_TDM) ? sarx_pkg::TDM_LAST :
                ((half_start ? half : slot[4]) ? sarx_pkg::TDM_LAST : sarx_pkg::HALF_LAST);
  end

  always_ff @(posedge link_clk) begin
    if (!link_rst_n) begin
      bclk_d   <= 1'b0;
      fs_d     <= 1'b0;
      running  <= 1'b0;
      wait_cnt <= '0;
      bitn     <= '0;
      slot     <= '0;
    end else begin
      bclk_d <= sel_bclk;
      if (latch) begin
        fs_d    <= sel_fsync;
        running <= eff_run;
        slot    <= eff_slot;
        bitn    <= eff_bitn;
        if (eff_run && eff_wait != 6'h00) begin
          wait_cnt <= eff_wait - 6'h01;
        end else if (shift_en) begin
          wait_cnt <= 6'h00;
          bitn     <= word_done ? 6'h00 : eff_bitn + 6'h01;
          if (word_done) begin
            slot    <= eff_slot + 5'h01;
            running <= (eff_slot != slot_last);
          end
        end
      end
    end
  end

  // one shifter per pin, shared timing
  logic [WW-1:0] pin_word [2];
  logic [WW-1:0] wl_mask;

  assign wl_mask = (l_wl == 6'h20) ? '1 : ((WW'(1) << l_wl) - WW'(1));

  genvar gp;
  generate
    for (gp = 0; gp < 2; gp++) begin : g_pin
      sarx_shift #(.WIDTH(WW)) u_shift (
        .clk      (link_clk),
        .rst_n    (link_rst_n),
        .shift_en (shift_en),
        .bit_in   (pins_s[gp]),
        .word_now (pin_word[gp])
      );
    end
  endgenerate

  // Per-channel capture and hand-over to aclk
  logic [WW-1:0]  ch_word [NCH];
  logic [NCH-1:0] ch_tog;
  logic [NCH-1:0] tog_s;
  logic [NCH-1:0] tog_d;

  sarx_sync #(.WIDTH(NCH)) u_tog_sync (
    .clk      (aclk),
    .async_in (ch_tog),
    .sync_out (tog_s)
  );

  assign word_event = tog_s ^ tog_d;

  generate
    for (gc = 0; gc < NCH; gc++) begin : g_cap
      always_ff @(posedge link_clk) begin
        if (!link_rst_n) begin
          ch_word[gc] <= '0;
          ch_tog[gc]  <= 1'b0;
        end else if (word_done && l_chan[gc*CW + sarx_pkg::CH_EN_BIT] &&
                     l_chan[gc*CW +: sarx_pkg::SLOT_W] == eff_slot) begin
          ch_word[gc] <= pin_word[l_pin_sel[gc]] & wl_mask;
          ch_tog[gc]  <= ~ch_tog[gc];
        end
      end

      // Word is stable for a frame after its toggle
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          tog_d[gc]              <= 1'b0;
          dac_valid[gc]          <= 1'b0;
          dac_data[gc*WW +: WW]  <= '0;
        end else begin
          tog_d[gc]     <= tog_s[gc];
          dac_valid[gc] <= word_event[gc];
          if (word_event[gc]) begin
            dac_data[gc*WW +: WW] <= ch_word[gc];
          end
        end
      end
    end
  endgenerate
endmodule // sarx_top
`default_nettype wire

// >>> tb/sarx_top_sva.sv
// Checker on the register bus and channel strobes of sarx_top.
// Assumes byte 0 strobed, one transfer at a time.
`timescale 1ns/100ps
`default_nettype none
module sarx_top_sva (
  // Clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic [31:0] wdata,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic        rvalid,
  input wire logic        rready,
  // Channel strobes
  input wire logic [7:0]  dac_valid
);
  logic [7:0] aw_q, wd_q, ra_q, fr_sh, ps_sh, en_sh;
  logic       fr_w, ps_w;
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // Shadow of OKAY writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {aw_q, wd_q, ra_q, fr_sh, ps_sh, en_sh, fr_w, ps_w} <= '0;
    end else begin
      if (awvalid && awready) aw_q <= awaddr;
      if (wvalid && wready) wd_q <= wdata[7:0];
      if (arvalid && arready) ra_q <= araddr;
      if (bvalid && bready && bresp == sarx_pkg::RESP_OKAY) begin
        if (aw_q == 8'h98) {fr_w, fr_sh} <= {1'b1, wd_q};
        if (aw_q == 8'h9c) {ps_w, ps_sh} <= {1'b1, wd_q};
        if (aw_q[7:5] == 3'h5) en_sh[aw_q[4:2]] <= wd_q[sarx_pkg::CH_EN_BIT];
      end
    end
  end
  property p_fr_reset; rvalid && ra_q == 8'h98 && !fr_w |-> rdata == 32'h0; endproperty
  a_fr_reset: assert property (p_fr_reset) else $error("framing not zero");
  property p_ps_reset; rvalid && ra_q == 8'h9c && !ps_w |-> rdata == 32'h0; endproperty
  a_ps_reset: assert property (p_ps_reset) else $error("pin select not zero");
  property p_edge; rvalid && ra_q == 8'h98 |-> rdata[7] == fr_sh[7]; endproperty
  a_edge: assert property (p_edge) else $error("edge bit lost");
  property p_fsync; $rose(rvalid) && ra_q == 8'h98 |-> rdata[6] == fr_sh[6]; endproperty
  a_fsync: assert property (p_fsync) else $error("frame sync bit lost");
  property p_bclk; rvalid && ra_q == 8'h98 |-> rdata[5] == fr_sh[5]; endproperty
  a_bclk: assert property (p_bclk) else $error("bit clock bit lost");
  property p_off;
    rvalid && ra_q == 8'h98 |-> rdata[4:0] == fr_sh[4:0] && rdata[31:8] == 24'h0;
  endproperty
  a_off: assert property (p_off) else $error("offset lost");
  property p_pinsel; rvalid && ra_q == 8'h9c |-> rdata == {24'h0, ps_sh}; endproperty
  a_pinsel: assert property (p_pinsel) else $error("pin select lost");
  property p_enable; dac_valid != 8'h0 |-> (dac_valid & ~en_sh) == 8'h0; endproperty
  a_enable: assert property (p_enable) else $error("disabled channel strobed");
endmodule // sarx_top_sva
bind sarx_top sarx_top_sva u_sva (
  .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wvalid, .wready, .bresp, .bvalid,
  .bready, .araddr, .arvalid, .arready, .rdata, .rvalid, .rready, .dac_valid
);
`default_nettype wire

// >>> tb/sarx_host.sv
// Host audio port model: one 194-bit frame per start.
// Assumes link_clk; 8 link_clk cycles a bit, clocks idle between frames.
`timescale 1ns/100ps
`default_nettype none
module sarx_host (
  // Link clock
  input wire logic         link_clk,
  // Frame request
  input wire logic         start,
  input wire logic         launch_rise,
  input wire logic         use_int_clk,
  input wire logic         use_int_sync,
  input wire logic [199:0] fs_bits,
  input wire logic [199:0] d1_bits,
  input wire logic [199:0] d2_bits,
  output logic             done,
  // Pins
  output logic             ext_bit_clock,
  output logic             ext_frame_sync,
  output logic             int_bit_clock,
  output logic             int_frame_sync,
  output logic             serial_input_pin_first,
  output logic             serial_input_pin_second
);
  logic bit_clk, sync, noise, d1, d2;
  initial {bit_clk, sync, noise, d1, d2, done} = '0;
  always @(posedge link_clk) noise <= ~noise;
  // bits placed as the bench built them
  always @(posedge start) begin
    done <= 1'b0;
    for (int i = 0; i < 194; i++) begin
      @(posedge link_clk);
      bit_clk <= launch_rise;
      sync <= fs_bits[i];
      d1 <= d1_bits[i];
      d2 <= d2_bits[i];
      repeat (4) @(posedge link_clk);
      bit_clk <= ~launch_rise;
      repeat (3) @(posedge link_clk);
    end
    repeat (4) @(posedge link_clk);
    // Released lines flip, no hold
    bit_clk <= 1'b0;
    sync <= 1'b0;
    d1 <= ~d1;
    d2 <= ~d2;
    done <= 1'b1;
  end
  assign ext_bit_clock  = use_int_clk ? noise : bit_clk;
  assign int_bit_clock  = use_int_clk ? bit_clk : noise;
  assign ext_frame_sync = use_int_sync ? ~sync : sync;
  assign int_frame_sync = use_int_sync ? sync : ~sync;
  assign serial_input_pin_first  = d1;
  assign serial_input_pin_second = d2;
endmodule // sarx_host
`default_nettype wire

// >>> tb/sarx_top_tb.sv
// Self-checking bench for sarx_top with sarx_host frames.
// Assumes the checker is bound in.
`timescale 1ns/100ps
`default_nettype none
module sarx_top_tb;
  // Rows: fmt[12:11] pol edge mode int_sync int_clk rand_en off[4:0]
  localparam logic [12:0] ROWS [8] = '{13'h0000, 13'h021f, 13'h0c01, 13'h1631,
                                       13'h0185, 13'h034a, 13'h00e3, 13'h09de};
  logic         aclk, aresetn, link_clk, awvalid, awready, wvalid, wready, bvalid, bready;
  logic         arvalid, arready, rvalid, rready, ebc, efs, ibc, ifs, pin1, pin2;
  logic         clr, start, done, lr, use_clk, use_sync;
  logic [7:0]   awaddr, araddr, dac_valid, seen;
  logic [31:0]  wdata, rdata;
  logic [3:0]   wstrb;
  logic [1:0]   bresp, rresp;
  logic [255:0] dac_data;
  logic [199:0] fsb, d1b, d2b;
  int           mismatches = 0, checks_done = 0;
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #24 link_clk = ~link_clk;
  end
  always @(posedge aclk) seen <= clr ? 8'h00 : seen | dac_valid;
  sarx_top dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
    .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .link_clk, .ext_bit_clock(ebc), .ext_frame_sync(efs),
    .serial_input_pin_first(pin1), .serial_input_pin_second(pin2),
    .int_bit_clock(ibc), .int_frame_sync(ifs), .dac_data, .dac_valid
  );
  sarx_host u_host (
    .link_clk, .start, .launch_rise(lr), .use_int_clk(use_clk),
    .use_int_sync(use_sync), .fs_bits(fsb), .d1_bits(d1b), .d2_bits(d2b), .done,
    .ext_bit_clock(ebc), .ext_frame_sync(efs), .int_bit_clock(ibc), .int_frame_sync(ifs),
    .serial_input_pin_first(pin1), .serial_input_pin_second(pin2)
  );
  task automatic check_val(input logic [31:0] seen_v, exp_v);
    checks_done++;
    if (seen_v !== exp_v) begin
      mismatches++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic timeout();
    mismatches++;
    $display("ERROR at %0t: wait ran out", $time);
    end_sim();
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    {awaddr, wdata, wstrb, awvalid, wvalid, bready} <= {a, d, 4'hf, 3'b111};
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (bvalid === 1'b1) break;
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end
    if (n == 100) timeout();
    r = bresp;
    bready <= 1'b0;
  endtask
  task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    {araddr, arvalid, rready} <= {a, 2'b11};
    for (n = 0; n < 100; n++) begin
      @(posedge aclk);
      if (rvalid === 1'b1) break;
      if (arready === 1'b1) arvalid <= 1'b0;
    end
    if (n == 100) timeout();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask
  function automatic int unsigned slot_of(logic [1:0] fmt, int c);
    return (fmt == sarx_pkg::FMT_TDM) ? c : (c % 2) * 16 + c / 2;
  endfunction
  // Two preamble bits, then halves of 96 bits; MSB moved by the offset
  function automatic int unsigned msb_pos(logic [1:0] fmt, logic [4:0] off, int unsigned s);
    return 2 + (s >= 16 ? 96 : 0) + (fmt == sarx_pkg::FMT_I2S ? 1 : 0) + off + 16 * (s % 16);
  endfunction
  function automatic logic [199:0] fs_vec(logic [1:0] fmt);
    logic [199:0] v;
    v = '0;
    for (int i = 2; i < 194; i++)
      v[i] = (fmt == sarx_pkg::FMT_TDM) ? (i == 2) : ((fmt == sarx_pkg::FMT_I2S) ^ (i < 98));
    v[1:0] = {2{~v[2]}};
    return v;
  endfunction
  function automatic logic [199:0] data_vec(logic [199:0] fill, logic [1:0] fmt,
                                            logic [4:0] off, logic [127:0] w);
    int unsigned p;
    for (int c = 0; c < 8; c++) begin
      p = msb_pos(fmt, off, slot_of(fmt, c));
      for (int b = 0; b < 16; b++)
        fill[p + b] = w[c * 16 + 15 - b];
    end
    return fill;
  endfunction
  task automatic run_row(input logic [12:0] row);
    logic [1:0]   r;
    logic [31:0]  d;
    logic [7:0]   ps, en, fr;
    logic [127:0] w1, w2;
    logic [199:0] f1, f2;
    int           n;
    ps = 8'($urandom);
    en = row[5] ? 8'($urandom) : 8'hff;
    fr = {row[9], row[7:6], row[4:0]};
    for (int i = 0; i < 200; i++)
      {f1[i], f2[i]} = 2'($urandom);
    for (int i = 0; i < 4; i++)
      {w1[i * 32 +: 32], w2[i * 32 +: 32]} = {$urandom, $urandom};
    axi_write(8'hc0, {26'h0, 2'h0, row[12:11], row[10], row[8]}, r);
    axi_write(8'h98, {24'h0, fr}, r);
    axi_write(8'h9c, {24'h0, ps}, r);
    for (int c = 0; c < 8; c++)
      axi_write(8'ha0 + 8'(4 * c), {26'h0, en[c], 5'(slot_of(row[12:11], c))}, r);
    axi_read(8'h98, d, r);
    check_val(d, {24'h0, fr});
    // Let the config crossing settle
    repeat (20) @(posedge aclk);
    fsb <= fs_vec(row[12:11]);
    d1b <= data_vec(f1, row[12:11], row[4:0], w1);
    d2b <= data_vec(f2, row[12:11], row[4:0], w2);
    lr <= row[10] ^ row[9];
    use_clk <= row[8] & row[6];
    use_sync <= row[8] & row[7];
    clr <= 1'b1;
    @(posedge aclk);
    clr <= 1'b0;
    start <= 1'b1;
    @(posedge aclk);
    for (n = 0; n < 5000 && done !== 1'b1; n++) @(posedge aclk);
    if (n == 5000) timeout();
    start <= 1'b0;
    for (n = 0; n < 100 && seen !== en; n++) @(posedge aclk);
    check_val({24'h0, seen}, {24'h0, en});
    for (int c = 0; c < 8; c++)
      if (en[c])
        check_val(dac_data[c * 32 +: 32], {16'h0, ps[c] ? w2[c * 16 +: 16] : w1[c * 16 +: 16]});
  endtask
  initial begin
    logic [31:0] d, q;
    logic [1:0]  r;
    {aresetn, awvalid, wvalid, bready, arvalid, rready, clr, start, lr, use_clk, use_sync} = '0;
    {awaddr, araddr, wdata, wstrb, fsb, d1b, d2b} = '0;
    void'($urandom(33));
    for (int k = 0; k < 2; k++) begin
      aresetn <= 1'b0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      axi_read(8'h98, d, r);
      check_val(d, 32'h0);
      axi_read(8'h9c, d, r);
      check_val(d, 32'h0);
      if (k == 1) end_sim();
      for (int c = 0; c < 8; c++) begin
        axi_read(8'ha0 + 8'(4 * c), d, r);
        check_val(d, 32'(c));
      end
      axi_read(8'h00, d, r);
      check_val({r, d[29:0]}, {sarx_pkg::RESP_ERR, 30'h0});
      axi_write(8'h04, 32'h1, r);
      check_val(32'(r), 32'(sarx_pkg::RESP_ERR));
      for (int i = 0; i < 4; i++) begin
        d = $urandom;
        axi_write(8'h98 + 8'(4 * (i % 2)), d, r);
        axi_read(8'h98 + 8'(4 * (i % 2)), q, r);
        check_val(q, {24'h0, d[7:0]});
      end
      for (int i = 0; i < 8; i++)
        run_row(ROWS[i]);
    end
  end
endmodule // sarx_top_tb
`default_nettype wire
